// ### verilog/iqm_defs.vh
`ifndef IQM_DEFS_VH
`define IQM_DEFS_VH
`define IQM_ADDR_W        4
`define IQM_REG_STATUS    4'h0
`define IQM_REG_QBASE     4'h1
`define IQM_REG_QLEN      4'h2
`define IQM_REG_CTRL      4'h3
`define IQM_REG_EVMASK    4'h4
`define IQM_REG_INFO      4'h5
`define IQM_IDX_HI        30
`define IQM_IDX_LO        16
`define IQM_FULL_BIT      15
`define IQM_CNT_HI        14
`define IQM_CNT_LO        0
`define IQM_LOST_BIT      15
`define IQM_IQ_DEPTH      128
`define IQM_IQ_AW         7
`define IQM_QLEN_MIN      16'h0002
`define IQM_QLEN_MAX      16'h8000
`define IQM_CTRL_SCR      0
`define IQM_CTRL_GINIT    1
`define IQM_CTRL_QREAD    2
`define IQM_CTRL_ENABLE   3
`define IQM_EV_W          8
`endif

// ### verilog/iqm_mask.v
`timescale 1ns/1ps
`include "iqm_defs.vh"
module iqm_mask (
  input  wire                   clk,
  input  wire                   rst_n,
  input  wire [`IQM_EV_W-1:0]   ev_valid,
  input  wire [`IQM_EV_W-1:0]   ev_mask,
  input  wire [`IQM_EV_W-1:0]   grp_mask,
  input  wire [`IQM_EV_W-1:0]   chan_mask,
  output reg  [`IQM_EV_W-1:0]   ev_pass
);
  genvar i;
  generate
    for (i = 0; i < `IQM_EV_W; i = i + 1) begin : g_src
      always @(posedge clk) begin
        if (!rst_n) begin
          ev_pass[i] <= 1'b0;
        end else begin
          ev_pass[i] <= ev_valid[i] & ~ev_mask[i] & ~grp_mask[i] & ~chan_mask[i];
        end
      end
    end
  endgenerate
endmodule

// ### verilog/iqm_fifo.v
`timescale 1ns/1ps
`include "iqm_defs.vh"
module iqm_fifo (
  input  wire          clk,
  input  wire          rst_n,
  input  wire          flush,
  input  wire          push,
  input  wire [31:0]   push_data,
  input  wire          pop,
  output wire [31:0]   head,
  output wire          empty,
  output wire          full,
  output wire [7:0]    level
);
  reg [31:0]            mem [0:`IQM_IQ_DEPTH-1];
  reg [`IQM_IQ_AW-1:0]  wr_ptr;
  reg [`IQM_IQ_AW-1:0]  rd_ptr;
  reg [7:0]             cnt;
  wire                  do_push;
  wire                  do_pop;
  wire [`IQM_IQ_AW-1:0] last_ptr;
  assign empty    = (cnt == 8'h00);
  assign full     = (cnt == 8'h80);
  assign level    = cnt;
  assign head     = mem[rd_ptr];
  assign do_pop   = pop & ~empty;
  assign do_push  = push & (~full | do_pop);
  assign last_ptr = wr_ptr - 7'h01;
  always @(posedge clk) begin
    if (do_push) begin
      mem[wr_ptr] <= push_data;
    end else if (push && full && !do_pop) begin
      mem[last_ptr][`IQM_LOST_BIT] <= 1'b1;
    end
  end
  always @(posedge clk) begin
    if (!rst_n || flush) begin
      wr_ptr <= 7'h00;
      rd_ptr <= 7'h00;
      cnt    <= 8'h00;
    end else begin
      if (do_push) begin
        wr_ptr <= wr_ptr + 7'h01;
      end
      if (do_pop) begin
        rd_ptr <= rd_ptr + 7'h01;
      end
      cnt <= cnt + {7'h00, do_push} - {7'h00, do_pop};
    end
  end
endmodule

// ### verilog/iqm_top.v
// Function
// - refresh status after each batch moved to shared memory.
// - clear status on reset, soft chip reset, queue config change.
// - bits 30:16 hold host service index, read/write.
// - only host writes service index; device only clears it.
// - bit 15 reads 1 when shared queue full; code sets it when a batch fills the queue, status read clears it.
// - bits 14:0 pending count since last read; writes ignored.
// - status read clears count and drops interrupt line.
// - reset state on reset, soft reset, init, queue read, pointer/length write.
// - initialization zeroes status and drops internal descriptors.
// - shared queue length two to 32768 dwords.
// - new queue accepted anytime, resetting interrupt logic.
// - mask conditions per group, channel, device configuration.
// - internal queue holds 128 descriptors awaiting bus mastership.
// - update count after writes; interrupt while count non-zero.
// - stop writing when shared queue full; resume after host frees space.
// - both queues full drops new descriptors, marks newest internal one.
// - lost marker is descriptor bit 15, rest intact.
//
// Implementation choices: the plain strobed port and the register offsets.
`timescale 1ns/1ps
`include "iqm_defs.vh"
module iqm_top (
  input  wire                    clk,
  input  wire                    rst_n,
  input  wire [`IQM_ADDR_W-1:0]  reg_addr,
  input  wire [31:0]             reg_wdata,
  input  wire                    reg_wr,
  input  wire                    reg_rd,
  output reg  [31:0]             reg_rdata,
  input  wire [`IQM_EV_W-1:0]    ev_valid,
  input  wire [31:0]             ev_desc,
  input  wire [`IQM_EV_W-1:0]    grp_mask,
  input  wire [`IQM_EV_W-1:0]    chan_mask,
  output reg                     bus_req,
  input  wire                    bus_gnt,
  output reg                     mem_wr,
  output reg  [31:0]             mem_addr,
  output reg  [31:0]             mem_wdata,
  input  wire                    mem_ack,
  output reg                     inta
);
  localparam ST_IDLE = 2'd0;
  localparam ST_REQ  = 2'd1;
  localparam ST_WR   = 2'd2;
  localparam ST_DONE = 2'd3;

  reg [1:0]            state;
  reg [14:0]           host_service_index;
  reg                  queue_full_flag;
  reg [14:0]           pending_count;
  reg [31:0]           qbase;
  reg [15:0]           qlen;
  reg                  enable;
  reg [`IQM_EV_W-1:0]  ev_mask;
  reg [14:0]           wr_index;
  reg [14:0]           batch_cnt;
  reg                  full_det;
  wire [`IQM_EV_W-1:0] ev_pass;
  wire [31:0]          fifo_head;
  wire                 fifo_empty;
  wire [7:0]           fifo_level;
  wire                 st_read;
  wire                 st_write;
  wire                 ctl_write;
  wire                 cfg_write;
  wire                 init;
  wire                 pop;
  wire [14:0]          next_wr_index;
  wire                 shared_full;
  wire [15:0]          used;

  assign st_read   = reg_rd && reg_addr == `IQM_REG_STATUS;
  assign st_write  = reg_wr && reg_addr == `IQM_REG_STATUS;
  assign ctl_write = reg_wr && reg_addr == `IQM_REG_CTRL;
  assign cfg_write = reg_wr && (reg_addr == `IQM_REG_QBASE || reg_addr == `IQM_REG_QLEN);
  assign init = cfg_write
              | (ctl_write & (reg_wdata[`IQM_CTRL_SCR] | reg_wdata[`IQM_CTRL_GINIT]
                              | reg_wdata[`IQM_CTRL_QREAD]));

  assign next_wr_index = ({1'b0, wr_index} + 16'h0001 >= qlen) ? 15'h0000 : wr_index + 15'h0001;
  assign used = (wr_index >= host_service_index)
              ? {1'b0, wr_index - host_service_index}
              : qlen - {1'b0, host_service_index} + {1'b0, wr_index};
  assign shared_full = (used + 16'h0001 >= qlen);
  assign pop = (state == ST_WR) && mem_ack;

  iqm_mask u_mask (
    .clk       (clk),
    .rst_n     (rst_n),
    .ev_valid  (ev_valid),
    .ev_mask   (ev_mask),
    .grp_mask  (grp_mask),
    .chan_mask (chan_mask),
    .ev_pass   (ev_pass)
  );

  iqm_fifo u_fifo (
    .clk       (clk),
    .rst_n     (rst_n),
    .flush     (init),
    .push      (|ev_pass),
    .push_data (ev_desc),
    .pop       (pop),
    .head      (fifo_head),
    .empty     (fifo_empty),
    .full      (),
    .level     (fifo_level)
  );

  // configuration registers
  always @(posedge clk) begin
    if (!rst_n) begin
      qbase   <= 32'h00000000;
      qlen    <= `IQM_QLEN_MIN;
      enable  <= 1'b0;
      ev_mask <= 8'h00;
    end else if (reg_wr) begin
      case (reg_addr)
        `IQM_REG_QBASE: qbase <= {reg_wdata[31:2], 2'b00};
        `IQM_REG_QLEN: begin
          if (reg_wdata[15:0] < `IQM_QLEN_MIN)
            qlen <= `IQM_QLEN_MIN;
          else if (reg_wdata[15:0] > `IQM_QLEN_MAX)
            qlen <= `IQM_QLEN_MAX;
          else
            qlen <= reg_wdata[15:0];
        end
        `IQM_REG_CTRL: begin
          if (reg_wdata[`IQM_CTRL_SCR]) begin
            enable  <= 1'b0;
            ev_mask <= 8'h00;
          end else begin
            enable <= reg_wdata[`IQM_CTRL_ENABLE];
          end
        end
        `IQM_REG_EVMASK: ev_mask <= reg_wdata[`IQM_EV_W-1:0];
        default: ;
      endcase
    end
  end

  // status register and transfer engine
  always @(posedge clk) begin
    if (!rst_n || init) begin
      state              <= ST_IDLE;
      host_service_index <= 15'h0000;
      queue_full_flag    <= 1'b0;
      pending_count      <= 15'h0000;
      wr_index           <= 15'h0000;
      batch_cnt          <= 15'h0000;
      full_det           <= 1'b0;
      bus_req            <= 1'b0;
      mem_wr             <= 1'b0;
      mem_addr           <= 32'h00000000;
      mem_wdata          <= 32'h00000000;
      inta               <= 1'b0;
    end else begin
      if (st_write)
        host_service_index <= reg_wdata[`IQM_IDX_HI:`IQM_IDX_LO];
      full_det <= 1'b0;
      case (state)
        ST_IDLE: begin
          if (enable && !fifo_empty && !shared_full) begin
            bus_req <= 1'b1;
            state   <= ST_REQ;
          end
        end
        ST_REQ: begin
          if (bus_gnt) begin
            mem_wr    <= 1'b1;
            mem_addr  <= qbase + {15'h0000, wr_index, 2'b00};
            mem_wdata <= fifo_head;
            state     <= ST_WR;
          end
        end
        ST_WR: begin
          if (mem_ack) begin
            mem_wr    <= 1'b0;
            wr_index  <= next_wr_index;
            batch_cnt <= batch_cnt + 15'h0001;
            if (fifo_level == 8'h01 || used + 16'h0002 >= qlen) begin
              full_det <= (used + 16'h0002 >= qlen);
              bus_req  <= 1'b0;
              state    <= ST_DONE;
            end else begin
              state <= ST_REQ;
            end
          end
        end
        ST_DONE: begin
          batch_cnt <= 15'h0000;
          state     <= ST_IDLE;
        end
        default: state <= ST_IDLE;
      endcase
      if (state == ST_DONE)
        pending_count <= st_read ? batch_cnt : pending_count + batch_cnt;
      else if (st_read)
        pending_count <= 15'h0000;
      if (full_det)
        queue_full_flag <= 1'b1;
      else if (st_read)
        queue_full_flag <= 1'b0;
      if (state == ST_DONE)
        inta <= st_read ? (batch_cnt != 15'h0000)
                        : ((pending_count + batch_cnt) != 15'h0000);
      else if (st_read)
        inta <= 1'b0;
    end
  end

  // read port
  always @(posedge clk) begin
    if (!rst_n) begin
      reg_rdata <= 32'h00000000;
    end else if (reg_rd) begin
      case (reg_addr)
        `IQM_REG_STATUS: reg_rdata <= {1'b0, host_service_index, queue_full_flag, pending_count};
        `IQM_REG_QBASE:  reg_rdata <= qbase;
        `IQM_REG_QLEN:   reg_rdata <= {16'h0000, qlen};
        `IQM_REG_CTRL:   reg_rdata <= {28'h0000000, enable, 3'b000};
        `IQM_REG_EVMASK: reg_rdata <= {24'h000000, ev_mask};
        `IQM_REG_INFO:   reg_rdata <= {9'h000, wr_index, fifo_level};
        default:         reg_rdata <= 32'h00000000;
      endcase
    end else begin
      reg_rdata <= 32'h00000000;
    end
  end
endmodule

// ### verification/iqm_top_asserts.sv
`timescale 1ns/1ps
`include "iqm_defs.vh"
module iqm_checker (
  input wire        clk,
  input wire        rst_n,
  input wire [3:0]  reg_addr,
  input wire [31:0] reg_wdata,
  input wire        reg_wr,
  input wire        reg_rd,
  input wire [31:0] reg_rdata,
  input wire        bus_req,
  input wire        bus_gnt,
  input wire        mem_wr,
  input wire [31:0] mem_addr,
  input wire [31:0] mem_wdata,
  input wire        mem_ack,
  input wire        inta
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  wire st_rd = reg_rd && reg_addr == `IQM_REG_STATUS;
  wire q_cfg = reg_wr && (reg_addr == `IQM_REG_QBASE || reg_addr == `IQM_REG_QLEN);
  wire c_ini = reg_wr && reg_addr == `IQM_REG_CTRL && reg_wdata[2:0] != 3'h0;
  AST_RD_DROP: assert property (st_rd && !$past(bus_req) |=> !inta)
    else $error("inta high after read");
  AST_CNT_INTA: assert property (st_rd |=> (reg_rdata[14:0] != 15'h0) == $past(inta))
    else $error("count and inta differ");
  AST_RSVD: assert property (st_rd |=> !reg_rdata[31])
    else $error("status bit 31 set");
  AST_HOLD: assert property (mem_wr && !mem_ack && !q_cfg && !c_ini |=>
    mem_wr && $stable(mem_addr) && $stable(mem_wdata)) else $error("write not held");
  AST_MASTER: assert property (mem_wr |-> bus_req && ($past(mem_wr) || $past(bus_gnt)))
    else $error("write without grant");
  AST_QCFG: assert property (q_cfg |=> !inta && !bus_req && !mem_wr)
    else $error("queue change left activity");
  AST_INIT: assert property (c_ini |=> !inta && !bus_req && !mem_wr)
    else $error("init left activity");
  AST_INTA_RISE: assert property ($rose(inta) |-> !$past(bus_req) && $past(bus_req, 2))
    else $error("inta rose outside batch end");
  cover property (st_rd && inta);
  cover property (mem_wr && mem_ack);
  cover property (c_ini);
endmodule
bind iqm_top iqm_checker u_chk (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .bus_req(bus_req), .bus_gnt(bus_gnt), .mem_wr(mem_wr), .mem_addr(mem_addr),
  .mem_wdata(mem_wdata), .mem_ack(mem_ack), .inta(inta));

// ### verification/iqm_mem_model.sv
`timescale 1ns/1ps
module iqm_mem_model (
  input  wire        clk,
  input  wire        rst_n,
  input  wire        slow,
  input  wire        bus_req,
  output reg         bus_gnt,
  input  wire        mem_wr,
  input  wire [31:0] mem_addr,
  input  wire [31:0] mem_wdata,
  output reg         mem_ack
);
  reg  [31:0] mem [0:255];
  reg  [1:0]  wt;
  wire        go = !slow || wt == 2'h2;
  always @(posedge clk) begin
    if (!rst_n) begin
      {bus_gnt, mem_ack, wt} <= 4'h0;
    end else begin
      wt      <= (mem_ack || !bus_req || (bus_gnt && !mem_wr)) ? 2'h0 : wt + 2'h1;
      bus_gnt <= bus_req && (bus_gnt || go);
      mem_ack <= mem_wr && !mem_ack && go;
      if (mem_wr && mem_ack)
        mem[mem_addr[9:2]] <= mem_wdata;
    end
  end
endmodule

// ### verification/tb_interrupt_queue_manager.sv
`timescale 1ns/1ps
`include "iqm_defs.vh"
module tb_interrupt_queue_manager;
  reg         clk = 1'b0, rst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, slow = 1'b0;
  reg  [3:0]  reg_addr = 4'h0;
  reg  [7:0]  ev_valid = 8'h00, grp_mask = 8'h80, chan_mask = 8'h40;
  reg  [31:0] reg_wdata = 32'h0, ev_desc = 32'h0;
  reg  [31:0] dq [0:129];
  wire [31:0] reg_rdata, mem_addr, mem_wdata;
  wire        bus_req, bus_gnt, mem_wr, mem_ack, inta;
  integer     err_total = 0, check_count = 0, cyc = 0, i, n, b;
  always #12.5 clk = ~clk;
  iqm_top u_dut (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .ev_valid(ev_valid),
    .ev_desc(ev_desc), .grp_mask(grp_mask), .chan_mask(chan_mask), .bus_req(bus_req),
    .bus_gnt(bus_gnt), .mem_wr(mem_wr), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
    .mem_ack(mem_ack), .inta(inta));
  iqm_mem_model u_mem (.clk(clk), .rst_n(rst_n), .slow(slow), .bus_req(bus_req),
    .bus_gnt(bus_gnt), .mem_wr(mem_wr), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
    .mem_ack(mem_ack));
  task end_sim;
    if (err_total == 0 && check_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc = cyc + 1;
    if (cyc == 20000) begin
      err_total = err_total + 1;
      end_sim;
    end
  end
  task chk(input [31:0] seen, input [31:0] exp);
    check_count = check_count + 1;
    if (seen !== exp) begin
      err_total = err_total + 1;
      $display("unexpected at %0t: %h vs %h", $time, seen, exp);
    end
  endtask
  function [31:0] stat(input [14:0] idx, input full, input [14:0] cnt);
    stat = {1'b0, idx, full, cnt};
  endfunction
  task wr(input [3:0] a, input [31:0] d);
    @(posedge clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk);
    reg_wr    <= 1'b0;
  endtask
  task rc(input [3:0] a, input [31:0] exp);
    @(posedge clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk);
    reg_rd   <= 1'b0;
    @(negedge clk);
    chk(reg_rdata, exp);
  endtask
  // masked sources first, then k unmasked descriptors
  task push(input integer k);
    @(posedge clk);
    ev_valid <= 8'he0;
    for (i = 0; i < k; i = i + 1) begin
      dq[i] = $urandom & 32'hffff7fff;
      @(posedge clk);
      ev_valid <= 8'h01 << ($urandom % 5);
      // descriptor is sampled one edge after its event
      if (i > 0)
        ev_desc <= dq[i-1];
    end
    @(posedge clk);
    ev_valid <= 8'h00;
    ev_desc  <= dq[k-1];
  endtask
  task wait_int;
    integer k;
    for (k = 0; k < 3000 && inta !== 1'b1; k = k + 1)
      @(negedge clk);
    chk({31'h0, inta}, 32'h1);
  endtask
  initial begin
    i = $urandom(96);
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    wr(4'hf, 32'hffffffff);
    rc(4'hf, 32'h0);
    rc(`IQM_REG_STATUS, 32'h0);
    wr(`IQM_REG_QLEN, 32'h1);
    rc(`IQM_REG_QLEN, 32'h2);
    wr(`IQM_REG_QLEN, 32'hffff);
    rc(`IQM_REG_QLEN, 32'h8000);
    wr(`IQM_REG_QBASE, 32'h7);
    rc(`IQM_REG_QBASE, 32'h4);
    wr(`IQM_REG_QBASE, 32'h0);
    wr(`IQM_REG_QLEN, 32'h8);
    wr(`IQM_REG_EVMASK, 32'h20);
    n = 1 + $urandom % 3;
    slow <= 1'($urandom % 2);
    push(n);
    rc(`IQM_REG_INFO, n);
    wr(`IQM_REG_CTRL, 32'h8);
    wait_int;
    rc(`IQM_REG_STATUS, stat(15'h0, 1'b0, n[14:0]));
    chk({31'h0, inta}, 32'h0);
    for (b = 0; b < n; b = b + 1)
      chk(u_mem.mem[b], dq[b]);
    rc(`IQM_REG_STATUS, 32'h0);
    wr(`IQM_REG_STATUS, 32'hffffffff);
    rc(`IQM_REG_STATUS, stat(15'h7fff, 1'b0, 15'h0));
    wr(`IQM_REG_QLEN, 32'h8);
    rc(`IQM_REG_STATUS, 32'h0);
    wr(`IQM_REG_CTRL, 32'h0);
    push(9);
    wr(`IQM_REG_CTRL, 32'h8);
    wait_int;
    rc(`IQM_REG_STATUS, stat(15'h0, 1'b1, 15'h7));
    rc(`IQM_REG_STATUS, 32'h0);
    wr(`IQM_REG_STATUS, stat(15'h7, 1'b0, 15'h0));
    wait_int;
    rc(`IQM_REG_STATUS, stat(15'h7, 1'b0, 15'h2));
    chk(u_mem.mem[7], dq[7]);
    chk(u_mem.mem[0], dq[8]);
    wr(`IQM_REG_QLEN, 32'h100);
    wr(`IQM_REG_CTRL, 32'h0);
    slow <= 1'b1;
    push(130);
    rc(`IQM_REG_INFO, 32'h80);
    wr(`IQM_REG_CTRL, 32'h8);
    wait_int;
    rc(`IQM_REG_STATUS, stat(15'h0, 1'b0, 15'h80));
    chk(u_mem.mem[126], dq[126]);
    chk(u_mem.mem[127], dq[127] | 32'h8000);
    wr(`IQM_REG_CTRL, 32'h0);
    for (b = 0; b < 3; b = b + 1) begin
      wr(`IQM_REG_STATUS, 32'h30000);
      push(2);
      wr(`IQM_REG_CTRL, 32'h1 << b);
      rc(`IQM_REG_INFO, 32'h0);
      rc(`IQM_REG_STATUS, 32'h0);
    end
    end_sim;
  end
endmodule
